// >>> design/supervisor_pkg.sv
/*
  Constants, state type and register map for the system supervisor.
  Assumes a 250 MHz system clock and a classic Wishbone master.
*/
// Function
// - Two independent watchdogs restart on rising edge
// - Programmed open and close counts per watchdog
// - Edge before window opens flags error
// - Window closing without edge flags error
// - Temperature warning raises controller interrupt
// - Temperature error shuts down, waits system-on toggle
// - No power-on progress while warning active
// - Measure internal versus external clock ratio
// - Async reset forces off, supplies off
// - Leave off: input good, on high, cool
// - Enable 1.1 V, then 1.8 V, then 3.3 V
// - Wait four rails good, hold reset, release
// - Standby drives host reset high
// - Standby exits: shutdown or off conditions
// - Software steps standby to powering to ready
// - Finish mirror power-up despite system-on low
// - Ready: illumination to on, park events park
// - Headlight mode never enters display on
// - Display on: illumination off returns ready
// - Parking holds park low, timers, then standby
// - Shutdown only on temp error, exits limited
// - Registers readable while in off state
// - Stay off while system-on sampled low
package supervisor_pkg;

  typedef enum logic [2:0] {
    ST_OFF, ST_SEQ, ST_STANDBY, ST_POWERING, ST_READY, ST_DISPLAY,
    ST_PARKING, ST_SHUTDOWN
  } sys_state_t;

  localparam int CLK_MHZ          = 250;
  localparam int RAIL_STEP_NS     = 1000;
  localparam int RAIL_STEP_CYC    = RAIL_STEP_NS * CLK_MHZ / 1000;
  localparam int HOST_RST_NS      = 10000;
  localparam int HOST_RST_CYC     = HOST_RST_NS * CLK_MHZ / 1000;
  localparam int PARK_NS          = 8000;
  localparam int PARK_CYC         = PARK_NS * CLK_MHZ / 1000;
  localparam int PARK_FINAL_NS    = 4000;
  localparam int PARK_FINAL_CYC   = PARK_FINAL_NS * CLK_MHZ / 1000;
  localparam int OSC_KHZ          = 2000;
  localparam int OSC_DIV          = CLK_MHZ * 1000 / OSC_KHZ;

  localparam logic [3:0] ADR_STATUS  = 4'h0;
  localparam logic [3:0] ADR_CONTROL = 4'h1;
  localparam logic [3:0] ADR_WD_A    = 4'h2;
  localparam logic [3:0] ADR_WD_B    = 4'h3;
  localparam logic [3:0] ADR_RATIO   = 4'h4;
  localparam logic [3:0] ADR_STATE   = 4'h5;

  localparam int ST_WD_A_ERR   = 7;
  localparam int ST_WD_B_ERR   = 6;
  localparam int ST_CHANGE     = 5;
  localparam int ST_TEMP_WARN  = 2;
  localparam int ST_TEMP_ERR   = 1;
  localparam int ST_ON_LOW     = 0;

  localparam int CT_WD_A_EN    = 0;
  localparam int CT_WD_B_EN    = 1;
  localparam int CT_MIRROR_EN  = 2;
  localparam int CT_MIRROR_OK  = 3;
  localparam int CT_ILLUM      = 4;
  localparam int CT_HEADLIGHT  = 5;
  localparam int CT_PARK       = 6;
  localparam int CT_CYCLE      = 7;
  localparam int CT_WARN_IE    = 8;

  localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] WD_RESET      = 32'h0000_0000;

endpackage

// >>> design/system_supervisor_fsm.sv
/*
  System supervisor: top state machine, rail sequencing, two windowed
  watchdogs, temperature reaction, clock ratio monitor, Wishbone slave.
  Assumes asynchronous pins arrive unsynchronised and the internal
  2 MHz oscillator is modelled as an enable divided from i_clk.
*/
// The implementer's own choices: register access over Wishbone and the placing of the registers.
module system_supervisor_fsm
  import supervisor_pkg::*;
#(
  parameter int WD_W    = 16,
  parameter int RATIO_W = 16,
  parameter int RATIO_N = 2000,
  parameter int HOST_RST_COUNT = HOST_RST_CYC,
  parameter int PARK_COUNT     = PARK_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_core_async_reset_n,
  input  wire logic        i_system_on_request,
  input  wire logic        i_main_input_voltage_good,
  input  wire logic [3:0]  i_rail_good,
  input  wire logic [1:0]  i_temp_warn,
  input  wire logic [1:0]  i_temp_err,
  input  wire logic        i_watchdog_a,
  input  wire logic        i_watchdog_b,
  input  wire logic        i_fast_ext_clock,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [5:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_host_reset_n,
  output logic             o_mirror_park_n,
  output logic [2:0]       o_rail_en,
  output logic             o_mirror_reg_en,
  output logic             o_temp_irq,
  output logic [2:0]       o_state
);

  localparam int NSYNC = 12;

  // Three-stage synchronisers for all asynchronous pins
  logic [NSYNC-1:0] sync_in, s1, s2, s3, next_s1;
  assign sync_in = {i_fast_ext_clock, i_watchdog_b, i_watchdog_a,
                    i_temp_err, i_temp_warn, i_rail_good,
                    i_main_input_voltage_good};
  logic on_s1, on_s2, on_s3;

  always_comb
  begin
    next_s1 = sync_in;
  end

  always_ff @(posedge i_clk)
  begin
    s1 <= next_s1;
    s2 <= s1;
    s3 <= s2;
    on_s1 <= i_system_on_request;
    on_s2 <= on_s1;
    on_s3 <= on_s2;
  end

  // Filtered levels: change once stages two and three agree
  logic [NSYNC-1:0] lvl, next_lvl;
  logic on_lvl, next_on_lvl;
  always_comb
  begin
    for (int i = 0; i < NSYNC; i++)
      next_lvl[i] = (s2[i] == s3[i]) ? s2[i] : lvl[i];
    next_on_lvl = (on_s2 == on_s3) ? on_s2 : on_lvl;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      lvl    <= '0;
      on_lvl <= 1'b0;
    end
    else
    begin
      lvl    <= next_lvl;
      on_lvl <= next_on_lvl;
    end
  end

  logic       main_input_voltage_good, warn, terr, ext_lvl;
  logic [3:0] rails;
  logic [1:0] wd_lvl;
  assign main_input_voltage_good = lvl[0];
  assign rails      = lvl[4:1];
  assign warn       = |lvl[6:5];
  assign terr       = |lvl[8:7];
  assign wd_lvl     = lvl[10:9] == 2'b00 ? 2'b00 : lvl[10:9];
  assign ext_lvl    = lvl[NSYNC-1];

  // Internal oscillator tick
  logic [7:0] osc_cnt, next_osc_cnt;
  logic       osc_tick;
  assign osc_tick = (osc_cnt == 8'(OSC_DIV - 1));
  always_comb
  begin
    next_osc_cnt = osc_tick ? 8'h00 : osc_cnt + 8'h01;
  end

  // Registers
  logic [31:0] status, next_status, control, next_control;
  logic [2*WD_W-1:0] wd_cfg [2];
  logic [2*WD_W-1:0] next_wd_cfg [2];
  logic [RATIO_W-1:0] ratio, next_ratio;
  logic [1:0] wd_err;
  logic       state_chg;
  sys_state_t state, next_state;

  logic bus_req, bus_wr;
  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign bus_wr  = bus_req && i_wb_we;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  sel);
    for (int b = 0; b < 4; b++)
      if (sel[b])
        old[8*b +: 8] = d[8*b +: 8];
    return old;
  endfunction

  // Windowed watchdogs
  logic [WD_W-1:0] wd_cnt [2];
  logic [WD_W-1:0] next_wd_cnt [2];
  logic [1:0] wd_prev, next_wd_prev, wd_run, next_wd_run;

  generate
    for (genvar w = 0; w < 2; w++)
    begin : g_wd
      logic en, rise;
      logic [WD_W-1:0] open_at, close_at;
      assign en       = control[CT_WD_A_EN + w];
      assign open_at  = wd_cfg[w][WD_W-1:0];
      assign close_at = wd_cfg[w][2*WD_W-1:WD_W];
      assign rise     = wd_lvl[w] && !wd_prev[w];
      always_comb
      begin
        next_wd_prev[w] = wd_lvl[w];
        next_wd_cnt[w]  = wd_cnt[w];
        next_wd_run[w]  = wd_run[w];
        wd_err[w]       = 1'b0;
        if (!en)
        begin
          next_wd_run[w] = 1'b0;
          next_wd_cnt[w] = '0;
        end
        else if (rise)
        begin
          wd_err[w]       = wd_run[w] && (wd_cnt[w] < open_at);
          next_wd_cnt[w]  = '0;
          next_wd_run[w]  = 1'b1;
        end
        else if (wd_run[w] && osc_tick)
        begin
          if (wd_cnt[w] >= close_at)
          begin
            wd_err[w]      = 1'b1;
            next_wd_cnt[w] = '0;
          end
          else
            next_wd_cnt[w] = wd_cnt[w] + WD_W'(1);
        end
      end
    end
  endgenerate

  // Clock ratio: external edges counted over RATIO_N oscillator ticks
  logic ext_prev, next_ext_prev;
  logic [RATIO_W-1:0] ext_cnt, next_ext_cnt, win_cnt, next_win_cnt;
  always_comb
  begin
    next_ext_prev = ext_lvl;
    next_ext_cnt  = ext_cnt + RATIO_W'(ext_lvl && !ext_prev);
    next_win_cnt  = win_cnt;
    next_ratio    = ratio;
    if (osc_tick)
    begin
      if (win_cnt == RATIO_W'(RATIO_N - 1))
      begin
        next_win_cnt = '0;
        next_ratio   = next_ext_cnt;
        next_ext_cnt = '0;
      end
      else
        next_win_cnt = win_cnt + RATIO_W'(1);
    end
  end

  // Top state machine
  logic [31:0] tmr, next_tmr;
  logic [1:0]  phase, next_phase;
  logic        park_ev;
  assign park_ev = !main_input_voltage_good || !on_lvl || terr
                 || control[CT_PARK] || control[CT_CYCLE];

  always_comb
  begin
    next_state = state;
    next_tmr   = tmr;
    next_phase = phase;
    unique case (state)
      ST_OFF:
        if (main_input_voltage_good && on_lvl && !warn)
        begin
          next_state = ST_SEQ;
          next_phase = 2'd0;
          next_tmr   = '0;
        end
      ST_SEQ:
        if (terr)
          next_state = ST_SHUTDOWN;
        else if (warn)
          next_tmr = tmr;
        else if (phase < 2'd3)
        begin
          if (tmr >= 32'(RAIL_STEP_CYC))
          begin
            next_phase = phase + 2'd1;
            next_tmr   = '0;
          end
          else
            next_tmr = tmr + 32'h1;
        end
        else if (&rails)
        begin
          if (tmr >= 32'(HOST_RST_COUNT))
            next_state = ST_STANDBY;
          else
            next_tmr = tmr + 32'h1;
        end
        else
          next_tmr = '0;
      ST_STANDBY:
        if (terr)
          next_state = ST_SHUTDOWN;
        else if (!on_lvl || control[CT_CYCLE] || |wd_err || !main_input_voltage_good)
          next_state = ST_OFF;
        else if (control[CT_MIRROR_EN])
          next_state = ST_POWERING;
      ST_POWERING:
        if (control[CT_MIRROR_OK])
          next_state = ST_READY;
      ST_READY:
        if (park_ev)
        begin
          next_state = ST_PARKING;
          next_tmr   = '0;
          next_phase = 2'd0;
        end
        else if (control[CT_ILLUM] && !control[CT_HEADLIGHT])
          next_state = ST_DISPLAY;
      ST_DISPLAY:
        if (park_ev)
        begin
          next_state = ST_PARKING;
          next_tmr   = '0;
          next_phase = 2'd0;
        end
        else if (!control[CT_ILLUM] || control[CT_HEADLIGHT])
          next_state = ST_READY;
      ST_PARKING:
        if (phase == 2'd0 && tmr >= 32'(PARK_COUNT))
        begin
          next_phase = 2'd1;
          next_tmr   = '0;
        end
        else if (phase == 2'd1 && tmr >= 32'(PARK_FINAL_CYC))
          next_state = ST_STANDBY;
        else
          next_tmr = tmr + 32'h1;
      ST_SHUTDOWN:
        if (!on_lvl || !main_input_voltage_good)
          next_state = ST_OFF;
    endcase
  end

  // Register updates; hardware set wins over software clear
  logic [31:0] hw_set;
  always_comb
  begin
    hw_set = '0;
    hw_set[ST_WD_A_ERR] = wd_err[0];
    hw_set[ST_WD_B_ERR] = wd_err[1];
    hw_set[ST_CHANGE]   = state_chg;
    hw_set[ST_TEMP_WARN] = warn;
    hw_set[ST_TEMP_ERR] = terr;
    hw_set[ST_ON_LOW]   = !on_lvl;
    next_status  = status;
    next_control = control;
    next_wd_cfg  = wd_cfg;
    if (bus_wr && i_wb_adr[5:2] == ADR_STATUS)
      next_status = status & ~merge('0, i_wb_dat, i_wb_sel);
    if (bus_wr && i_wb_adr[5:2] == ADR_CONTROL)
      next_control = merge(control, i_wb_dat, i_wb_sel);
    for (int k = 0; k < 2; k++)
      if (bus_wr && i_wb_adr[5:2] == ADR_WD_A + 4'(k))
        next_wd_cfg[k] = (2*WD_W)'(merge(32'(wd_cfg[k]), i_wb_dat,
                                         i_wb_sel));
    next_status = next_status | hw_set;
    if (next_state == ST_OFF || next_state == ST_SHUTDOWN)
      next_control[CT_CYCLE] = 1'b0;
    if (state == ST_PARKING)
      next_control[CT_PARK] = 1'b0;
  end

  assign state_chg = (next_state != state);

  always_ff @(posedge i_clk or negedge i_core_async_reset_n)
  begin
    if (!i_core_async_reset_n)
      state <= ST_OFF;
    else if (!i_resetn)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      tmr      <= '0;
      phase    <= 2'd0;
      osc_cnt  <= 8'h00;
      status   <= STATUS_RESET;
      control  <= CONTROL_RESET;
      wd_cfg   <= '{default: WD_RESET[2*WD_W-1:0]};
      wd_cnt   <= '{default: '0};
      wd_prev  <= 2'b00;
      wd_run   <= 2'b00;
      ext_prev <= 1'b0;
      ext_cnt  <= '0;
      win_cnt  <= '0;
      ratio    <= '0;
    end
    else
    begin
      tmr      <= next_tmr;
      phase    <= next_phase;
      osc_cnt  <= next_osc_cnt;
      status   <= next_status;
      control  <= next_control;
      wd_cfg   <= next_wd_cfg;
      wd_cnt   <= next_wd_cnt;
      wd_prev  <= next_wd_prev;
      wd_run   <= next_wd_run;
      ext_prev <= next_ext_prev;
      ext_cnt  <= next_ext_cnt;
      win_cnt  <= next_win_cnt;
      ratio    <= next_ratio;
    end
  end

  // Outputs; supplies drop asynchronously with the core reset
  logic [2:0] next_rail_en;
  logic       supplies_on;
  assign supplies_on = state != ST_OFF && state != ST_SHUTDOWN;
  always_comb
  begin
    next_rail_en = 3'b000;
    if (supplies_on)
      next_rail_en = (state == ST_SEQ) ?
        ((phase == 2'd0) ? 3'b001 : (phase == 2'd1) ? 3'b011 : 3'b111)
        : 3'b111;
  end

  always_ff @(posedge i_clk or negedge i_core_async_reset_n)
  begin
    if (!i_core_async_reset_n)
    begin
      o_rail_en       <= 3'b000;
      o_host_reset_n  <= 1'b0;
      o_mirror_park_n <= 1'b1;
      o_mirror_reg_en <= 1'b0;
      o_temp_irq      <= 1'b0;
      o_state         <= 3'h0;
    end
    else if (!i_resetn)
    begin
      o_rail_en       <= 3'b000;
      o_host_reset_n  <= 1'b0;
      o_mirror_park_n <= 1'b1;
      o_mirror_reg_en <= 1'b0;
      o_temp_irq      <= 1'b0;
      o_state         <= 3'h0;
    end
    else
    begin
      o_rail_en       <= next_rail_en;
      o_host_reset_n  <= supplies_on && next_state != ST_SEQ;
      o_mirror_park_n <= next_state != ST_PARKING;
      o_mirror_reg_en <= next_state == ST_POWERING
        || next_state == ST_READY || next_state == ST_DISPLAY
        || (next_state == ST_PARKING && next_phase == 2'd0);
      o_temp_irq      <= warn && control[CT_WARN_IE];
      o_state         <= 3'(next_state);
    end
  end

  // Wishbone slave: one wait state, reads work in every state
  logic [31:0] rd, next_rd;
  logic        next_ack;
  always_comb
  begin
    next_ack = bus_req;
    unique case (i_wb_adr[5:2])
      ADR_STATUS:  next_rd = status;
      ADR_CONTROL: next_rd = control;
      ADR_WD_A:    next_rd = 32'(wd_cfg[0]);
      ADR_WD_B:    next_rd = 32'(wd_cfg[1]);
      ADR_RATIO:   next_rd = 32'(ratio);
      ADR_STATE:   next_rd = 32'(state);
      default:     next_rd = 32'h0000_0000;
    endcase
  end
  assign rd = o_wb_dat;

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= next_ack;
      o_wb_dat <= next_ack ? next_rd : rd;
    end
  end

  // Assertions
  property p_off_supplies;
    @(posedge i_clk) disable iff (!i_resetn)
    $past(state) == ST_OFF && state == ST_OFF |-> o_rail_en == 3'b000;
  endproperty
  a_off_supplies: assert property (p_off_supplies)
    else $error("supplies on in off state");

  property p_leave_off;
    @(posedge i_clk) disable iff (!i_resetn)
    state == ST_OFF && next_state != ST_OFF |-> main_input_voltage_good && on_lvl && !warn;
  endproperty
  a_leave_off: assert property (p_leave_off)
    else $error("off left without conditions");

  property p_seq_order;
    @(posedge i_clk) disable iff (!i_resetn)
    o_rail_en[2] |-> o_rail_en[1] && o_rail_en[0];
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("rail order broken");

  property p_shutdown_entry;
    @(posedge i_clk) disable iff (!i_resetn)
    state != ST_SHUTDOWN ##1 state == ST_SHUTDOWN |-> $past(terr);
  endproperty
  a_shutdown_entry: assert property (p_shutdown_entry)
    else $error("shutdown without temperature error");

  property p_no_display_headlight;
    @(posedge i_clk) disable iff (!i_resetn)
    control[CT_HEADLIGHT] && state == ST_READY |=> state != ST_DISPLAY;
  endproperty
  a_no_display_headlight: assert property (p_no_display_headlight)
    else $error("display on in headlight mode");

  property p_park_pin;
    @(posedge i_clk) disable iff (!i_resetn)
    state == ST_PARKING |-> !o_mirror_park_n;
  endproperty
  a_park_pin: assert property (p_park_pin)
    else $error("park pin not low while parking");

  property p_powering_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    state == ST_POWERING && !control[CT_MIRROR_OK] |=> state == ST_POWERING;
  endproperty
  a_powering_hold: assert property (p_powering_hold)
    else $error("mirror power-up abandoned");

  property p_wd_err_flag;
    @(posedge i_clk) disable iff (!i_resetn)
    wd_err[0] |=> status[ST_WD_A_ERR];
  endproperty
  a_wd_err_flag: assert property (p_wd_err_flag)
    else $error("watchdog error not flagged");

  property p_standby_reset;
    @(posedge i_clk) disable iff (!i_resetn)
    state == ST_STANDBY |=> o_host_reset_n || state != ST_STANDBY;
  endproperty
  a_standby_reset: assert property (p_standby_reset)
    else $error("host reset low in standby");

  c_standby: cover property (@(posedge i_clk) state == ST_STANDBY);
  c_display: cover property (@(posedge i_clk) state == ST_DISPLAY);
  c_parking: cover property (@(posedge i_clk)
    state == ST_PARKING ##1 state == ST_STANDBY);
  c_wd_err:  cover property (@(posedge i_clk) |wd_err);

endmodule

// >>> sim/ctrl_model.sv
/*
  Display controller model: pulses both watchdog inputs at set periods.
  Assumes the bench sets the periods; pulses only while host is out of
  reset, a period of zero stops that input.
*/
module ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_host_reset_n,
  input  wire logic [15:0] i_period_a,
  input  wire logic [15:0] i_period_b,
  output logic             o_watchdog_a,
  output logic             o_watchdog_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_a = 16'h0;
  logic [15:0] cnt_b = 16'h0;

  // One rising edge per period, high for eight cycles
  always @(posedge i_clk)
  begin
    cnt_a <= (!i_host_reset_n || cnt_a + 16'h1 >= i_period_a) ? 16'h0
             : cnt_a + 16'h1;
    cnt_b <= (!i_host_reset_n || cnt_b + 16'h1 >= i_period_b) ? 16'h0
             : cnt_b + 16'h1;
    o_watchdog_a <= i_host_reset_n && i_period_a != 0 && cnt_a < 16'h8;
    o_watchdog_b <= i_host_reset_n && i_period_b != 0 && cnt_b < 16'h8;
  end
endmodule

// >>> sim/tb.sv
/*
  Self-checking bench for the system supervisor.
  Assumes a 250 MHz clock, classic Wishbone access and the controller
  model driving the watchdog pins.
*/
module tb;
  import supervisor_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] e; logic [31:0] m; int tol;} note_t;
  note_t notes[$];
  note_t cur;
  logic i_clk = 0, i_resetn = 0, core_n = 1, sys_on = 0, main_good = 1;
  logic fast_clk = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] rail_good = 4'h0, sel = 4'h0;
  logic [1:0] warn = 2'h0, terr = 2'h0;
  logic [5:0] adr = 6'h0;
  logic [31:0] wdat = 32'h0;
  logic [15:0] per_a = 16'h0, per_b = 16'h0;
  logic [2:0] prev_rail = 3'h0;
  wire logic [31:0] rdat;
  wire logic [2:0] rail_en, st;
  wire logic ack, host_n, park_n, mreg, irq, wd_a, wd_b;
  integer seed = 58;
  int n_mismatch = 0, samples_checked = 0;

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) rail_good <= {main_good, rail_en};
  always
  begin
    repeat (5) @(posedge i_clk);
    fast_clk <= ~fast_clk;
  end

  system_supervisor_fsm #(.RATIO_N(20), .HOST_RST_COUNT(10),
    .PARK_COUNT(10)) system_supervisor_fsm_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_core_async_reset_n(core_n),
    .i_system_on_request(sys_on), .i_main_input_voltage_good(main_good),
    .i_rail_good(rail_good), .i_temp_warn(warn), .i_temp_err(terr),
    .i_watchdog_a(wd_a), .i_watchdog_b(wd_b), .i_fast_ext_clock(fast_clk),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_host_reset_n(host_n), .o_mirror_park_n(park_n),
    .o_rail_en(rail_en), .o_mirror_reg_en(mreg), .o_temp_irq(irq),
    .o_state(st));

  ctrl_model ctrl_model_inst (.i_clk(i_clk), .i_host_reset_n(host_n),
    .i_period_a(per_a), .i_period_b(per_b), .o_watchdog_a(wd_a),
    .o_watchdog_b(wd_b));

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0 && notes.size() == 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input int tol = 0);
    samples_checked++;
    if ((^got) === 1'bx || got > exp + tol || got + tol < exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= d;
    sel <= 4'hf;
    @(posedge i_clk);
    while (ack !== 1'b1) @(posedge i_clk);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, m,
                    input int tol = 0);
    notes.push_back('{e, m, tol});
    wb(0, a, 32'h0);
  endtask

  task automatic wait_st(input sys_state_t s, input int lim);
    int i;
    i = 0;
    while (st !== s && i < lim)
    begin
      @(negedge i_clk);
      i++;
    end
    chk(st, s);
  endtask

  // Read data checked against the oldest note
  always @(posedge i_clk)
    if (ack === 1'b1 && we === 1'b0)
    begin
      if (notes.size() == 0)
        chk(32'hx, 32'h0);
      else
      begin
        cur = notes.pop_front();
        chk(rdat & cur.m, cur.e, cur.tol);
      end
    end

  // Rails only step up one at a time or drop to all off
  always @(posedge i_clk)
  begin
    if (rail_en !== prev_rail)
      chk(rail_en == 0 || rail_en == {prev_rail[1:0], 1'b1}, 1);
    prev_rail <= rail_en;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    close_out;
  end

  initial
  begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1;
    rd(ADR_STATE, 0, 32'h7);
    repeat (8) @(posedge i_clk);
    rd(ADR_STATUS, 32'h1, 32'h1);
    rd(4'h6, 0, 32'hffffffff);
    wb(1, 4'h7, 32'h5a5a_5a5a);
    rd(4'h7, 0, 32'hffffffff);
    @(posedge i_clk);
    warn <= 2'b10;
    sys_on <= 1;
    repeat (40) @(negedge i_clk);
    chk(st, ST_OFF);
    @(posedge i_clk);
    warn <= 2'b00;
    wait_st(ST_STANDBY, 1500);
    @(negedge i_clk);
    chk(host_n, 1);
    wb(1, ADR_CONTROL, 32'h100);
    @(posedge i_clk);
    warn <= 2'b01;
    repeat (8) @(negedge i_clk);
    chk(irq, 1);
    rd(ADR_STATUS, 32'h4, 32'h4);
    @(posedge i_clk);
    warn <= 2'b00;
    wb(1, ADR_WD_A, 32'h0008_0002);
    wb(1, ADR_WD_B, 32'h0008_0002);
    @(posedge i_clk);
    per_a <= 16'(400 + $unsigned($random(seed)) % 500);
    per_b <= 16'd100;
    wb(1, ADR_CONTROL, 32'h1);
    repeat (5)
    begin
      @(posedge wd_a);
      per_a <= 16'(400 + $unsigned($random(seed)) % 500);
    end
    chk(st, ST_STANDBY);
    rd(ADR_STATUS, 0, 32'hc0);
    @(posedge wd_a);
    per_a <= 16'd100;
    wait_st(ST_OFF, 2000);
    @(posedge i_clk);
    per_a <= 0;
    per_b <= 0;
    rd(ADR_STATUS, 32'h80, 32'h80);
    wb(1, ADR_CONTROL, 0);
    wb(1, ADR_STATUS, 32'h80);
    wait_st(ST_STANDBY, 1500);
    rd(ADR_STATUS, 0, 32'h80);
    @(posedge i_clk);
    per_b <= 16'd500;
    repeat (700) @(posedge i_clk);
    wb(1, ADR_CONTROL, 32'h2);
    repeat (1500) @(posedge i_clk);
    @(posedge wd_b);
    per_b <= 0;
    wait_st(ST_OFF, 2500);
    rd(ADR_STATUS, 32'h40, 32'hc0);
    wb(1, ADR_CONTROL, 0);
    wait_st(ST_STANDBY, 1500);
    wb(1, ADR_CONTROL, 32'h4);
    wait_st(ST_POWERING, 20);
    @(posedge i_clk);
    sys_on <= 0;
    repeat (10) @(negedge i_clk);
    chk(st, ST_POWERING);
    chk(mreg, 1);
    wb(1, ADR_CONTROL, 32'hc);
    wait_st(ST_READY, 20);
    wait_st(ST_PARKING, 20);
    @(negedge i_clk);
    chk(park_n, 0);
    chk(mreg, 1);
    repeat (20) @(negedge i_clk);
    chk(mreg, 0);
    wait_st(ST_OFF, 1500);
    wb(1, ADR_CONTROL, 0);
    @(posedge i_clk);
    sys_on <= 1;
    wait_st(ST_SEQ, 20);
    @(posedge i_clk);
    warn <= 2'b01;
    repeat (1200) @(negedge i_clk);
    chk(st, ST_SEQ);
    chk(host_n, 0);
    @(posedge i_clk);
    warn <= 2'b00;
    wait_st(ST_STANDBY, 1500);
    wb(1, ADR_CONTROL, 32'h4);
    wb(1, ADR_CONTROL, 32'hc);
    wb(1, ADR_CONTROL, 32'h1c);
    wait_st(ST_DISPLAY, 20);
    wb(1, ADR_CONTROL, 32'hc);
    wait_st(ST_READY, 20);
    wb(1, ADR_CONTROL, 32'h3c);
    repeat (20) @(negedge i_clk);
    chk(st, ST_READY);
    wb(1, ADR_CONTROL, 32'h40);
    wait_st(ST_PARKING, 20);
    wait_st(ST_STANDBY, 1500);
    rd(ADR_STATE, ST_STANDBY, 32'h7);
    wb(1, ADR_CONTROL, 32'h80);
    wait_st(ST_OFF, 20);
    wait_st(ST_STANDBY, 1500);
    @(posedge i_clk);
    terr <= 2'b01;
    wait_st(ST_SHUTDOWN, 20);
    @(negedge i_clk);
    chk(rail_en, 0);
    chk(host_n, 0);
    @(posedge i_clk);
    terr <= 2'b00;
    repeat (50) @(negedge i_clk);
    chk(st, ST_SHUTDOWN);
    @(posedge i_clk);
    sys_on <= 0;
    wait_st(ST_OFF, 20);
    @(posedge i_clk);
    sys_on <= 1;
    wait_st(ST_STANDBY, 1500);
    @(posedge i_clk);
    core_n <= 0;
    #1;
    chk(st, ST_OFF);
    chk(rail_en, 0);
    chk(host_n, 0);
    @(posedge i_clk);
    core_n <= 1;
    wait_st(ST_STANDBY, 1500);
    @(posedge i_clk);
    main_good <= 0;
    wait_st(ST_OFF, 20);
    @(posedge i_clk);
    main_good <= 1;
    rd(ADR_RATIO, 32'd250, 32'hffff, 3);
    repeat (4) @(posedge i_clk);
    close_out;
  end
endmodule
